/* src/rsc_pkg.sv */
// Summary of operation
// - Reset loads PC 0, ACC 0, SP 07h
// - Any enabled source asserts internal reset
// - LVR gated by disable bit, WDT by enable
// - Pin low pulses under 2us ignored
// - Wait 16ms after pin release
// - Five clock processing, then vector 0000h
// - Config read after 256x28h ticks
// - Config read on power-on cycle only
// - Power-on sets only power-on flag, 80h
// - Other resets set only own flag
// - Flags clear by writing 0 or power-on
// - Parity failure reset sets parity flag
// - Stop release with rearm clears disable bit
// - Threshold codes 0000..1101 valid only
// - LVR control cleared only by power-on
// - Indicator flag and enable bit provided
// - Stop wake restarts stabilization timer
package rsc_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_MHZ       = 200;
    localparam int FILT_NS       = 2000;
    localparam int FILT_CYC      = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRC_MHZ       = 8;
    localparam int IRC_DIV       = 8;
    localparam int PRE_CYC       = CLK_MHZ * IRC_DIV / IRC_MHZ;
    localparam int CFG_BLOCKS    = 256;
    localparam int CFG_MULT      = 'h28;
    localparam int CFG_TICKS_DEF = CFG_BLOCKS * CFG_MULT;
    localparam int STAB_MS       = 16;
    localparam int STAB_TICKS_DEF = STAB_MS * 1000 * IRC_MHZ / IRC_DIV;
    localparam int PROC_CYC      = 5;
    localparam int CNT_W         = 16;
    localparam int FILT_W        = 10;
    localparam int PRE_W         = 8;
    localparam int ADDR_W        = 12;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_LVI_CTRL  = 8'h86;
    localparam logic [7:0] IDX_LVR_CTRL  = 8'hD8;
    localparam logic [7:0] IDX_CAUSE     = 8'hE8;
    // Cause flag layout
    localparam int F_POR = 7;
    localparam int F_PIN = 6;
    localparam int F_WDT = 5;
    localparam int F_DBG = 4;
    localparam int F_LVR = 3;
    localparam int F_PAR = 0;
    localparam logic [7:0] CAUSE_RST  = 8'h80;
    localparam logic [7:0] CAUSE_MASK = 8'hF9;
    // Low-voltage reset control layout
    localparam int LR_REARM = 7;
    localparam int LR_THR   = 1;
    localparam int LR_DIS   = 0;
    localparam logic [7:0] LVR_RST  = 8'h00;
    localparam logic [7:0] LVR_MASK = 8'h9F;
    localparam logic [3:0] THR_MAX  = 4'hD;
    // Indicator control layout
    localparam int LI_FLAG = 5;
    localparam int LI_EN   = 4;
    localparam int LI_LVL  = 0;
    localparam logic [7:0] LVI_RST  = 8'h00;
    localparam logic [7:0] LVI_MASK = 8'h3F;
    // CPU state loaded on reset
    localparam logic [15:0] PC_RST  = 16'h0000;
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [7:0]  SP_RST  = 8'h07;
    localparam logic [15:0] VEC_ADDR = 16'h0000;

    typedef enum logic [4:0] {
        ST_HOLD = 5'b00001,
        ST_STAB = 5'b00010,
        ST_PROC = 5'b00100,
        ST_RUN  = 5'b01000,
        ST_WAKE = 5'b10000
    } rsc_st_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } rsc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rsc_apb_rsp_t;

    typedef struct packed {
        logic por_detect;
        logic wdt_overflow;
        logic lvr_detect;
        logic parity_fail;
        logic debug_reset;
    } rsc_src_t;
endpackage

/* src/rsc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module rsc_top #(
    parameter logic [rsc_pkg::CNT_W-1:0] CFG_TICKS  = rsc_pkg::CFG_TICKS_DEF[rsc_pkg::CNT_W-1:0],
    parameter logic [rsc_pkg::CNT_W-1:0] STAB_TICKS = rsc_pkg::STAB_TICKS_DEF[rsc_pkg::CNT_W-1:0]
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire rsc_pkg::rsc_apb_req_t apb_req,
    output var  rsc_pkg::rsc_apb_rsp_t apb_rsp,
    input  wire logic                  ext_reset_pin_n,
    input  wire rsc_pkg::rsc_src_t     src,
    input  wire logic                  watchdog_enable_bit,
    input  wire logic                  lvi_detect,
    input  wire logic                  stop_release,
    output logic                       sys_reset_n,
    output logic                       cfg_read,
    output logic                       cpu_start,
    output logic                       cpu_hold,
    output logic [15:0]                boot_vector,
    output logic [15:0]                pc_init,
    output logic [7:0]                 acc_init,
    output logic [7:0]                 sp_init,
    output logic                       periph_clk_on,
    output logic                       low_volt_reset_disable,
    output logic [3:0]                 reset_threshold_sel,
    output logic                       indicator_enable,
    output logic [3:0]                 indicator_level_sel
);
    import rsc_pkg::*;

    typedef struct packed {
        rsc_st_t            st;
        logic [FILT_W-1:0]  filt_cnt;
        logic               filt_low;
        logic [PRE_W-1:0]   pre_cnt;
        logic [CNT_W-1:0]   tick_cnt;
        logic               por_cycle;
        logic [7:0]         cause;
        logic [7:0]         lvr_ctrl;
        logic [7:0]         lvi_ctrl;
        rsc_apb_rsp_t       rsp;
        logic               sys_reset_n;
        logic               cfg_read;
        logic               cpu_start;
        logic               cpu_hold;
        logic               clk_on;
        logic [15:0]        pc_init;
        logic [7:0]         acc_init;
        logic [7:0]         sp_init;
    } rsc_state_t;

    localparam rsc_state_t RST_STATE = '{
        st:          ST_HOLD,
        filt_cnt:    '0,
        filt_low:    1'b0,
        pre_cnt:     '0,
        tick_cnt:    '0,
        por_cycle:   1'b1,
        cause:       CAUSE_RST,
        lvr_ctrl:    LVR_RST,
        lvi_ctrl:    LVI_RST,
        rsp:         '0,
        sys_reset_n: 1'b0,
        cfg_read:    1'b0,
        cpu_start:   1'b0,
        cpu_hold:    1'b0,
        clk_on:      1'b1,
        pc_init:     PC_RST,
        acc_init:    ACC_RST,
        sp_init:     SP_RST
    };

    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);
    localparam logic [PRE_W-1:0]  PRE_LAST  = PRE_W'(PRE_CYC - 1);
    localparam logic [CNT_W-1:0]  PROC_LAST = CNT_W'(PROC_CYC - 1);

    rsc_state_t s_r;
    rsc_state_t s_nxt;
    logic       tick;
    logic       wdt_rst;
    logic       lvr_rst;
    logic       any_src;
    logic       setup;
    logic       wr_en;
    logic [7:0] set_v;
    logic [7:0] wbyte;

    // Byte address match of a register index
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == {2'b00, idx, 2'b00});
    endfunction

    // Source gating and bus phase decode
    assign tick    = (s_r.pre_cnt == PRE_LAST);
    assign wdt_rst = src.wdt_overflow & watchdog_enable_bit;
    assign lvr_rst = src.lvr_detect & ~s_r.lvr_ctrl[LR_DIS];
    assign any_src = s_r.filt_low | src.por_detect | wdt_rst | lvr_rst
                   | src.parity_fail | src.debug_reset;
    assign setup   = apb_req.psel & ~apb_req.penable;
    assign wr_en   = apb_req.psel & apb_req.penable & s_r.rsp.pready & apb_req.pwrite
                   & apb_req.pstrb[0] & ~s_r.rsp.pslverr;
    assign wbyte   = apb_req.pwdata[7:0];

    // Cause events seen this cycle
    always_comb begin
        set_v        = 8'h00;
        set_v[F_PIN] = s_r.filt_low;
        set_v[F_WDT] = wdt_rst;
        set_v[F_DBG] = src.debug_reset;
        set_v[F_LVR] = lvr_rst;
        set_v[F_PAR] = src.parity_fail;
    end

    // Next state of the whole block
    always_comb begin
        s_nxt           = s_r;
        s_nxt.cfg_read  = 1'b0;
        s_nxt.cpu_start = 1'b0;
        s_nxt.pc_init   = PC_RST;
        s_nxt.acc_init  = ACC_RST;
        s_nxt.sp_init   = SP_RST;
        s_nxt.clk_on    = 1'b1;
        s_nxt.pre_cnt   = tick ? '0 : s_r.pre_cnt + 1'b1;

        // Pin noise canceller: low must persist before it counts
        if (ext_reset_pin_n) begin
            s_nxt.filt_cnt = '0;
            s_nxt.filt_low = 1'b0;
        end else if (s_r.filt_cnt == FILT_LAST) begin
            s_nxt.filt_low = 1'b1;
        end else begin
            s_nxt.filt_cnt = s_r.filt_cnt + 1'b1;
        end

        // Sequencer
        case (s_r.st)
            ST_HOLD: begin
                s_nxt.sys_reset_n = 1'b0;
                s_nxt.pre_cnt     = '0;  // Whole ticks only
                if (!any_src) begin
                    s_nxt.st       = ST_STAB;
                    s_nxt.tick_cnt = '0;
                end
            end
            ST_STAB: begin
                if (tick) begin
                    s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
                    if (s_r.por_cycle && s_r.tick_cnt == CFG_TICKS - 1'b1) begin
                        s_nxt.cfg_read = 1'b1;
                    end
                    if (s_r.tick_cnt == STAB_TICKS - 1'b1) begin
                        s_nxt.st       = ST_PROC;
                        s_nxt.tick_cnt = '0;
                    end
                end
            end
            ST_PROC: begin
                if (s_r.tick_cnt == PROC_LAST) begin
                    s_nxt.st          = ST_RUN;
                    s_nxt.sys_reset_n = 1'b1;
                    s_nxt.cpu_start   = 1'b1;
                    s_nxt.por_cycle   = 1'b0;
                end else begin
                    s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
                end
            end
            ST_RUN: begin
                if (stop_release) begin
                    s_nxt.st       = ST_WAKE;
                    s_nxt.cpu_hold = 1'b1;
                    s_nxt.pre_cnt  = '0;
                    s_nxt.tick_cnt = '0;
                end
            end
            ST_WAKE: begin
                if (tick) begin
                    s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
                    if (s_r.tick_cnt == STAB_TICKS - 1'b1) begin
                        s_nxt.st       = ST_RUN;
                        s_nxt.cpu_hold = 1'b0;
                    end
                end
            end
            default: begin
                s_nxt.st = ST_HOLD;
            end
        endcase

        // Any active source restarts the sequence
        if (any_src) begin
            s_nxt.st          = ST_HOLD;
            s_nxt.sys_reset_n = 1'b0;
            s_nxt.cpu_hold    = 1'b0;
            s_nxt.tick_cnt    = '0;
            s_nxt.lvi_ctrl    = LVI_RST;
            if (src.por_detect) begin
                s_nxt.por_cycle = 1'b1;
            end
        end

        // Low-voltage reset control
        if (wr_en && reg_hit(apb_req.paddr, IDX_LVR_CTRL)) begin
            s_nxt.lvr_ctrl[LR_REARM] = wbyte[LR_REARM];
            s_nxt.lvr_ctrl[LR_DIS]   = wbyte[LR_DIS];
            if (wbyte[LR_THR +: 4] <= THR_MAX) begin
                s_nxt.lvr_ctrl[LR_THR +: 4] = wbyte[LR_THR +: 4];
            end
        end
        if (stop_release && s_r.lvr_ctrl[LR_REARM]) begin
            s_nxt.lvr_ctrl[LR_DIS] = 1'b0;
        end
        if (src.por_detect) begin
            s_nxt.lvr_ctrl = LVR_RST;
        end

        // Indicator control, detection wins over a write
        if (wr_en && reg_hit(apb_req.paddr, IDX_LVI_CTRL) && !any_src) begin
            s_nxt.lvi_ctrl = wbyte & LVI_MASK;
        end
        if (lvi_detect && s_r.lvi_ctrl[LI_EN]) begin
            s_nxt.lvi_ctrl[LI_FLAG] = 1'b1;
        end

        // Cause flags: write 0 clears, a new event wins
        if (wr_en && reg_hit(apb_req.paddr, IDX_CAUSE)) begin
            s_nxt.cause = s_r.cause & wbyte & CAUSE_MASK;
        end
        s_nxt.cause = s_nxt.cause | set_v;
        if (src.por_detect) begin
            s_nxt.cause = CAUSE_RST;
        end

        // Bus answer prepared in the setup cycle
        s_nxt.rsp = '0;
        if (setup) begin
            s_nxt.rsp.pready = 1'b1;
            if (reg_hit(apb_req.paddr, IDX_CAUSE)) begin
                s_nxt.rsp.prdata = {24'h000000, s_r.cause};
            end else if (reg_hit(apb_req.paddr, IDX_LVR_CTRL)) begin
                s_nxt.rsp.prdata = {24'h000000, s_r.lvr_ctrl};
            end else if (reg_hit(apb_req.paddr, IDX_LVI_CTRL)) begin
                s_nxt.rsp.prdata = {24'h000000, s_r.lvi_ctrl};
            end else begin
                s_nxt.rsp.pslverr = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register, boot_vector from VEC_ADDR
    assign apb_rsp                = s_r.rsp;
    assign sys_reset_n            = s_r.sys_reset_n;
    assign cfg_read               = s_r.cfg_read;
    assign cpu_start              = s_r.cpu_start;
    assign cpu_hold               = s_r.cpu_hold;
    assign boot_vector            = VEC_ADDR;
    assign pc_init                = s_r.pc_init;
    assign acc_init               = s_r.acc_init;
    assign sp_init                = s_r.sp_init;
    assign periph_clk_on          = s_r.clk_on;
    assign low_volt_reset_disable = s_r.lvr_ctrl[LR_DIS];
    assign reset_threshold_sel    = s_r.lvr_ctrl[LR_THR +: 4];
    assign indicator_enable       = s_r.lvi_ctrl[LI_EN];
    assign indicator_level_sel    = s_r.lvi_ctrl[LI_LVL +: 4];

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence proc_five;
        (s_r.st == ST_PROC)[*5];
    endsequence
    sequence run_start;
        (s_r.st == ST_RUN) && s_r.cpu_start && s_r.sys_reset_n;
    endsequence

    a_cpu_init_vals: assert property (
        s_r.cpu_start |-> pc_init == PC_RST && acc_init == ACC_RST && sp_init == SP_RST)
        else $error("reset state values wrong");
    a_source_resets: assert property (
        src.debug_reset |=> !sys_reset_n && s_r.st == ST_HOLD)
        else $error("source did not hold reset");
    a_pin_resets: assert property (
        s_r.filt_low |=> !sys_reset_n && s_r.st == ST_HOLD)
        else $error("filtered pin did not hold reset");
    a_wdt_gated: assert property (
        (s_r.st == ST_RUN) && src.wdt_overflow && !watchdog_enable_bit && !s_r.filt_low
        && !src.por_detect && !src.lvr_detect && !src.parity_fail && !src.debug_reset
        |=> sys_reset_n)
        else $error("gated watchdog caused reset");
    a_lvr_gated: assert property (
        (s_r.st == ST_RUN) && src.lvr_detect && s_r.lvr_ctrl[LR_DIS] && !s_r.filt_low
        && !src.por_detect && !wdt_rst && !src.parity_fail && !src.debug_reset
        |=> sys_reset_n)
        else $error("disabled low-voltage detect caused reset");
    a_filter_len: assert property (
        $rose(s_r.filt_low) |-> $past(s_r.filt_cnt) == FILT_LAST && $past(!ext_reset_pin_n))
        else $error("pin filter too short");
    a_stab_hold: assert property (
        (s_r.st == ST_STAB) |-> !sys_reset_n)
        else $error("reset released during stabilization");
    a_proc_five: assert property (
        $rose(s_r.st == ST_PROC) |-> proc_five ##1 run_start)
        else $error("processing not five cycles");
    a_cfg_point: assert property (
        s_r.cfg_read |-> $past(s_r.por_cycle) && $past(s_r.st == ST_STAB) && $past(tick)
        && $past(s_r.tick_cnt) == CFG_TICKS - 1'b1)
        else $error("config read at wrong tick");
    a_por_flags: assert property (
        src.por_detect |=> s_r.cause == CAUSE_RST && s_r.lvr_ctrl == LVR_RST)
        else $error("power-on flags wrong");
    a_one_flag: assert property (
        src.debug_reset && !src.por_detect |=> s_r.cause[F_DBG])
        else $error("debug cause flag not set");
    a_flag_clear: assert property (
        wr_en && reg_hit(apb_req.paddr, IDX_CAUSE) && !wbyte[F_WDT] && !wdt_rst
        && !src.por_detect |=> !s_r.cause[F_WDT])
        else $error("flag not cleared by write");
    a_par_flag: assert property (
        src.parity_fail && !src.por_detect |=> s_r.cause[F_PAR])
        else $error("parity cause flag not set");
    a_rearm_stop: assert property (
        stop_release && s_r.lvr_ctrl[LR_REARM] && !src.por_detect |=> !low_volt_reset_disable)
        else $error("rearm did not clear disable");
    a_thr_refused: assert property (
        wr_en && reg_hit(apb_req.paddr, IDX_LVR_CTRL) && (wbyte[LR_THR +: 4] > THR_MAX)
        && !src.por_detect |=> $stable(reset_threshold_sel))
        else $error("unavailable threshold code taken");
    a_lvr_retain: assert property (
        any_src && !src.por_detect && !wr_en && !stop_release |=> $stable(s_r.lvr_ctrl))
        else $error("low-voltage control lost on reset");
    a_ind_flag: assert property (
        lvi_detect && s_r.lvi_ctrl[LI_EN] |=> s_r.lvi_ctrl[LI_FLAG])
        else $error("indicator flag not set");
    a_wake_hold: assert property (
        (s_r.st == ST_RUN) && stop_release && !any_src |=> cpu_hold && s_r.st == ST_WAKE)
        else $error("stop release did not hold cpu");

endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rsc_pkg::*;
    logic         pclk;
    logic         presetn;
    rsc_apb_req_t req;
    rsc_apb_rsp_t rsp;
    logic         pin_n;
    rsc_src_t     src;
    logic         wden;
    logic         lvi_det;
    logic         stop_rel;
    logic         rst_n, cfg_rd, start, hold, clk_on, dis, ien;
    logic [15:0]  vec, pc;
    logic [7:0]   acc, sp;
    logic [3:0]   thr_o, lvl_o;
    logic [3:0]   thr, lvl;
    logic [7:0]   m_cause, m_lvr, m_lvi;
    logic [31:0]  q;
    logic         err;
    int           n_mismatch, tests_run, cyc, n_cfg, k;
    int           sv[4] = '{3, 0, 1, 2};
    int           fb[4] = '{F_WDT, F_DBG, F_PAR, F_LVR};

    rsc_top #(.CFG_TICKS(16'h0004), .STAB_TICKS(16'h0008)) u_dut (
        .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .ext_reset_pin_n(pin_n), .src(src), .watchdog_enable_bit(wden),
        .lvi_detect(lvi_det), .stop_release(stop_rel), .sys_reset_n(rst_n),
        .cfg_read(cfg_rd), .cpu_start(start), .cpu_hold(hold), .boot_vector(vec),
        .pc_init(pc), .acc_init(acc), .sp_init(sp), .periph_clk_on(clk_on),
        .low_volt_reset_disable(dis), .reset_threshold_sel(thr_o),
        .indicator_enable(ien), .indicator_level_sel(lvl_o));

    // Free running clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Hang guard and config read pulse counter
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            complete_run();
        end
    end
    always @(negedge pclk) if (cfg_rd === 1'b1) n_cfg++;

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= {2'b00, idx, 2'b00};
        req.pwdata  <= {24'h000000, d};
        req.pstrb   <= 4'hF;
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        q   = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        chk("pready", n < 50, 1);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk("read data", q, {24'h000000, exp});
        chk("pslverr", err, 0);
    endtask

    // Wait for internal reset release, counting cycles
    task automatic wait_run(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (rst_n !== 1'b1 && n < 5000);
        chk("release", n < 5000, 1);
        chk("cpu_start", start, 1);
    endtask

    // Hold one reset source for n cycles
    task automatic trig(input int s, input int n, input logic hit);
        int w;
        @(posedge pclk);
        src <= rsc_src_t'(5'h01 << s);
        repeat (n) @(posedge pclk);
        src <= '0;
        @(negedge pclk);
        chk("sys_reset_n", rst_n, !hit);
        if (hit) wait_run(w);
        if (hit) m_lvi = 8'h00;
    endtask

    task automatic stop_pulse();
        @(posedge pclk);
        stop_rel <= 1'b1;
        @(posedge pclk);
        stop_rel <= 1'b0;
        repeat (2) @(negedge pclk);
        chk("cpu_hold", hold, 1);
        k = 0;
        while (hold !== 1'b0 && k < 3000) begin
            @(negedge pclk);
            k++;
        end
        chk("hold end", k < 3000, 1);
    endtask

    initial begin
        void'($urandom(83929));
        presetn = 1'b0;
        req = '0;
        pin_n = 1'b1;
        src = '0;
        wden = 1'b0;
        lvi_det = 1'b0;
        stop_rel = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        wait_run(k);
        chk("pc", pc, PC_RST);
        chk("acc", acc, ACC_RST);
        chk("sp", sp, SP_RST);
        chk("clock on", clk_on, 1);
        chk("vector", vec, 16'h0000);
        chk("config reads", n_cfg, 1);
        chk("stab wait", k >= 8 * PRE_CYC, 1);
        m_cause = CAUSE_RST;
        m_lvr = 8'h00;
        m_lvi = 8'h00;
        rd(IDX_CAUSE, m_cause);
        rd(IDX_LVR_CTRL, m_lvr);
        rd(IDX_LVI_CTRL, m_lvi);
        apb(1'b0, 8'h40, 8'h00);
        chk("unmapped err", err, 1);
        chk("unmapped data", q, 0);
        apb(1'b1, IDX_CAUSE, 8'h00);
        m_cause = 8'h00;
        rd(IDX_CAUSE, m_cause);
        thr = 4'($urandom % 14);
        m_lvr = {1'b1, 2'b00, thr, 1'b0};
        apb(1'b1, IDX_LVR_CTRL, m_lvr);
        rd(IDX_LVR_CTRL, m_lvr);
        chk("threshold", thr_o, thr);
        apb(1'b1, IDX_LVR_CTRL, 8'h9C);
        rd(IDX_LVR_CTRL, m_lvr);
        // Each enabled source sets only its own flag
        wden <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            trig(sv[i], 2 + $urandom % 8, 1'b1);
            m_cause[fb[i]] = 1'b1;
            rd(IDX_CAUSE, m_cause);
            rd(IDX_LVR_CTRL, m_lvr);
        end
        apb(1'b1, IDX_CAUSE, ~(8'h01 << F_WDT));
        m_cause[F_WDT] = 1'b0;
        rd(IDX_CAUSE, m_cause);
        wden <= 1'b0;
        trig(3, 4, 1'b0);
        rd(IDX_CAUSE, m_cause);
        // Disabled low-voltage reset ignores a detection
        m_lvr = {m_lvr[7], 2'b00, 4'h0, 1'b1};
        apb(1'b1, IDX_LVR_CTRL, m_lvr);
        trig(2, 4, 1'b0);
        // Stop release with and without rearm
        for (int r = 0; r < 2; r++) begin
            m_lvr = {r[0], 2'b00, 4'h0, 1'b1};
            apb(1'b1, IDX_LVR_CTRL, m_lvr);
            stop_pulse();
            m_lvr[0] = !r[0];
            rd(IDX_LVR_CTRL, m_lvr);
            chk("disable", dis, m_lvr[0]);
        end
        // Short pin pulse filtered, long pulse resets
        pin_n <= 1'b0;
        repeat (100) @(posedge pclk);
        pin_n <= 1'b1;
        repeat (3) @(negedge pclk);
        chk("glitch", rst_n, 1);
        @(posedge pclk);
        pin_n <= 1'b0;
        repeat (10000 / CLK_PERIOD_NS) @(posedge pclk);
        pin_n <= 1'b1;
        @(negedge pclk);
        chk("pin reset", rst_n, 0);
        wait_run(k);
        chk("pin stab", k >= 8 * PRE_CYC, 1);
        m_cause[F_PIN] = 1'b1;
        m_lvi = 8'h00;
        rd(IDX_CAUSE, m_cause);
        // Indicator flag and enable
        lvl = 4'($urandom);
        m_lvi = {4'h1, lvl};
        apb(1'b1, IDX_LVI_CTRL, m_lvi);
        @(negedge pclk);
        chk("ind enable", ien, 1);
        chk("ind level", lvl_o, lvl);
        @(posedge pclk);
        lvi_det <= 1'b1;
        @(posedge pclk);
        lvi_det <= 1'b0;
        m_lvi[5] = 1'b1;
        rd(IDX_LVI_CTRL, m_lvi);
        // Power-on clears flags and low-voltage control
        trig(4, 3, 1'b1);
        m_cause = CAUSE_RST;
        m_lvr = 8'h00;
        rd(IDX_CAUSE, m_cause);
        rd(IDX_LVR_CTRL, m_lvr);
        rd(IDX_LVI_CTRL, m_lvi);
        chk("config reads", n_cfg, 2);
        complete_run();
    end
endmodule
`default_nettype wire
